//--- pkg/bridge_pin_pkg.sv
// constants, register map and field layout of the bridge status pin logic
package bridge_pin_pkg;
   // timing
   localparam int unsigned CLK_HZ            = 200_000_000;
   localparam int unsigned POLL_MS           = 20;
   localparam int unsigned POLL_CYCLES       = CLK_HZ / 1000 * POLL_MS;
   localparam int unsigned EEPROM_US         = 2000;
   localparam int unsigned EEPROM_CYCLES     = CLK_HZ / 1_000_000 * EEPROM_US;
   localparam int unsigned REF_HZ            = 24_000_000;
   // register byte offsets
   localparam logic [7:0] CFG_OFS            = 8'h00;
   localparam logic [7:0] GPIO_OUT_OFS       = 8'h04;
   localparam logic [7:0] GPIO_OE_OFS        = 8'h08;
   localparam logic [7:0] CTRL_OFS           = 8'h0C;
   localparam logic [7:0] STATUS_OFS         = 8'h10;
   localparam logic [7:0] IRQ_WORD_OFS       = 8'h14;
   localparam logic [7:0] SENSE_OFS          = 8'h18;
   localparam logic [7:0] DEFAULTS_OFS       = 8'h1C;
   // configuration byte 8 fields
   localparam int unsigned CFG_MEDIA_EN_BIT   = 0;
   localparam int unsigned CFG_MEDIA_POL_BIT  = 1;
   localparam int unsigned CFG_SPEED_IND_BIT  = 2;
   localparam int unsigned CFG_ATA_FLOAT_BIT  = 4;
   localparam int unsigned CFG_ATA_DETECT_BIT = 6;
   // control register fields
   localparam int unsigned CTRL_HS_BIT        = 0;
   localparam int unsigned CTRL_SUSPEND_BIT   = 1;
   localparam int unsigned CTRL_ATA_ACT_BIT   = 2;
   localparam int unsigned CTRL_DELIVER_BIT   = 3;
   localparam int unsigned CTRL_SENSE_ACK_BIT = 4;
   // interrupt word fields
   localparam int unsigned IW_BUS_PWR_BIT     = 8;
   localparam int unsigned IW_HS_BIT          = 9;
   // reset values; gpio defaults stand for config bytes 0x09 and 0x0A
   localparam logic [7:0] CFG_RST            = 8'h00;
   localparam logic [5:0] GPIO_OUT_RST       = 6'h00;
   localparam logic [5:0] GPIO_OE_RST        = 6'h00;
   // sense codes and axi response codes
   localparam logic [7:0] ASC_NO_MEDIA       = 8'h3A;
   localparam logic [7:0] ASC_CHANGED        = 8'h28;
   localparam logic [7:0] ASQ_ZERO           = 8'h00;
   localparam logic [1:0] AXI_OKAY           = 2'b00;
   localparam logic [1:0] AXI_SLVERR         = 2'b10;
endpackage

//--- logic/pin_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule
`default_nettype wire

//--- logic/bridge_status_pins.sv
// status and control pin logic of the usb to ata bridge, axi4-lite slave
//
// Overview of operation
// - after reset release, vbus-present decides whether the d+ pull-up connects
// - vbus-present sampled once at start-up, then every 20 ms
// - sampled vbus high attaches d+ pull-up; low releases it
// - vbus low floats ata pins unless float option bit 4 is one
// - eeprom pins active for a few milliseconds at start-up, then quiet
// - all timing derives from one reference clock
// - interrupt pipe requests get nak while nothing is pending
// - pending data returns a 16-bit word: speed, bus power, gpio levels
// - byte 0 holds gpio 5..0, byte 1 bus power bit 0, high speed bit 1
// - config bit 0 enables media detection, bit 1 selects its polarity
// - media absent reports sense 0x3A qualifier 0x00
// - media returning after absence reports sense 0x28 qualifier 0x00
// - gpio default settings load from configuration at start-up
// - host may change gpio settings during operation; device applies them
// - config bit 2 makes gpio 2 show the usb speed
// - speed indicator is one for full speed, zero for high speed
// - low-power indicator driven zero while active, floated while suspended
// - ata pull-up enable is one while ata bus active, else zero
// - ata pull-up enable floats with the ata pins
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module bridge_status_pins #(
   parameter int unsigned POLL_CYCLES   = bridge_pin_pkg::POLL_CYCLES,
   parameter int unsigned EEPROM_CYCLES = bridge_pin_pkg::EEPROM_CYCLES,
   parameter logic [5:0]  GPIO_OUT_DEF  = bridge_pin_pkg::GPIO_OUT_RST,
   parameter logic [5:0]  GPIO_OE_DEF   = bridge_pin_pkg::GPIO_OE_RST
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // board pins
   input  wire logic        vbus_present_input,
   input  wire logic        system_service_request,
   input  wire logic        removable_media_present,
   input  wire logic        bus_powered_select,
   input  wire logic [5:0]  gpio_in,
   output logic [5:0]       gpio_out,
   output logic [5:0]       gpio_oe,
   output logic             dplus_pullup_en,
   output logic             ata_pins_oe,
   output logic             ata_pullup_control_out,
   output logic             ata_pullup_control_oe,
   output logic             active_state_indicator_out,
   output logic             active_state_indicator_oe,
   output logic             eeprom_active,
   // usb interrupt pipe
   input  wire logic        irq_pipe_request,
   output logic             irq_pipe_nak,
   output logic             irq_pipe_ack,
   output logic [15:0]      irq_pipe_word
);
   typedef enum logic [1:0] {ST_EEPROM, ST_FIRST_POLL, ST_RUN} boot_state_t;

   // synchronised pin inputs
   logic [9:0] pins_sync;
   pin_sync #(.W(10)) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({gpio_in, bus_powered_select, removable_media_present,
               system_service_request, vbus_present_input}),
      .q     (pins_sync)
   );
   wire       vbus_s    = pins_sync[0];
   wire       sreq_s    = pins_sync[1];
   wire       media_s   = pins_sync[2];
   wire       buspwr_s  = pins_sync[3];
   wire [5:0] gpio_s    = pins_sync[9:4];

   // registers; clk stands in for the single reference
   logic [7:0]  cfg_reg;
   logic [5:0]  gpio_out_reg, gpio_oe_reg;
   logic [2:0]  ctrl_reg;
   boot_state_t boot_reg, boot_next;
   logic [31:0] cnt_reg;
   logic        vbus_reg, sreq_d_reg, pending_reg;
   logic [15:0] word_reg;
   logic        media_seen_reg, changed_reg;
   logic        aw_hold_reg, w_hold_reg;
   logic [7:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;

   wire high_speed_status = ctrl_reg[bridge_pin_pkg::CTRL_HS_BIT];
   wire suspend           = ctrl_reg[bridge_pin_pkg::CTRL_SUSPEND_BIT];
   wire ata_act           = ctrl_reg[bridge_pin_pkg::CTRL_ATA_ACT_BIT];
   wire float_ok          = cfg_reg[bridge_pin_pkg::CFG_ATA_FLOAT_BIT];

   // start-up sequencing and 20 ms poll timer
   wire cnt_done = (cnt_reg == 32'h0000_0000);
   always_comb begin
      boot_next = boot_reg;
      case (boot_reg)
         // counter reads zero before it is armed, so wait for the window to open
         ST_EEPROM:     if (cnt_done && eeprom_active) boot_next = ST_FIRST_POLL;
         ST_FIRST_POLL: boot_next = ST_RUN;
         ST_RUN:        boot_next = ST_RUN;
         default:       boot_next = ST_EEPROM;
      endcase
   end
   wire poll_now = (boot_reg == ST_FIRST_POLL) || (boot_reg == ST_RUN && cnt_done);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         boot_reg <= ST_EEPROM;
         cnt_reg  <= 32'h0000_0000;
         vbus_reg <= 1'b0;
      end else begin
         boot_reg <= boot_next;
         if (boot_reg == ST_EEPROM && cnt_reg == 32'h0000_0000 && !eeprom_active)
            cnt_reg <= 32'(EEPROM_CYCLES - 1);
         else if (poll_now)
            cnt_reg <= 32'(POLL_CYCLES - 1);
         else if (!cnt_done)
            cnt_reg <= cnt_reg - 32'h0000_0001;
         if (poll_now)
            vbus_reg <= vbus_s;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         eeprom_active <= 1'b0;
      else
         eeprom_active <= (boot_next == ST_EEPROM);
   end

   // media detection
   wire media_on  = cfg_reg[bridge_pin_pkg::CFG_MEDIA_EN_BIT]
                  & (media_s ~^ cfg_reg[bridge_pin_pkg::CFG_MEDIA_POL_BIT]);
   wire media_abs = cfg_reg[bridge_pin_pkg::CFG_MEDIA_EN_BIT] & ~media_on;

   // axi4-lite write path: address and data taken in either order
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take  = s_axi_wvalid & s_axi_wready;
   wire do_wr   = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
   wire wr_cfg  = do_wr && aw_addr_reg == bridge_pin_pkg::CFG_OFS && w_strb_reg[0];
   wire wr_gout = do_wr && aw_addr_reg == bridge_pin_pkg::GPIO_OUT_OFS && w_strb_reg[0];
   wire wr_goe  = do_wr && aw_addr_reg == bridge_pin_pkg::GPIO_OE_OFS && w_strb_reg[0];
   wire wr_ctrl = do_wr && aw_addr_reg == bridge_pin_pkg::CTRL_OFS && w_strb_reg[0];
   wire wr_ok   = aw_addr_reg == bridge_pin_pkg::CFG_OFS
               || aw_addr_reg == bridge_pin_pkg::GPIO_OUT_OFS
               || aw_addr_reg == bridge_pin_pkg::GPIO_OE_OFS
               || aw_addr_reg == bridge_pin_pkg::CTRL_OFS;
   wire deliver_sw = wr_ctrl & w_data_reg[bridge_pin_pkg::CTRL_DELIVER_BIT];
   wire sense_ack  = wr_ctrl & w_data_reg[bridge_pin_pkg::CTRL_SENSE_ACK_BIT];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg  <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg  <= 32'h0000_0000;
         w_strb_reg  <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= bridge_pin_pkg::AXI_OKAY;
      end else begin
         if (aw_take) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
         end else if (do_wr) begin
            aw_hold_reg <= 1'b0;
         end
         if (w_take) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end else if (do_wr) begin
            w_hold_reg <= 1'b0;
         end
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? bridge_pin_pkg::AXI_OKAY : bridge_pin_pkg::AXI_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= ~aw_hold_reg & ~aw_take & ~s_axi_awready;
         s_axi_wready  <= ~w_hold_reg & ~w_take & ~s_axi_wready;
      end
   end

   // software state: config, gpio and control
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_reg      <= bridge_pin_pkg::CFG_RST;
         gpio_out_reg <= GPIO_OUT_DEF;
         gpio_oe_reg  <= GPIO_OE_DEF;
         ctrl_reg     <= 3'b000;
      end else begin
         if (wr_cfg)  cfg_reg      <= w_data_reg[7:0];
         if (wr_gout) gpio_out_reg <= w_data_reg[5:0];
         if (wr_goe)  gpio_oe_reg  <= w_data_reg[5:0];
         if (wr_ctrl) ctrl_reg     <= w_data_reg[2:0];
      end
   end

   // service request latch and interrupt pipe
   wire sreq_rise = sreq_s & ~sreq_d_reg;
   wire [15:0] word_now = {6'h00, high_speed_status, buspwr_s, 2'b00, gpio_s};
   wire pipe_deliver = irq_pipe_request & pending_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sreq_d_reg    <= 1'b0;
         pending_reg   <= 1'b0;
         word_reg      <= 16'h0000;
         irq_pipe_nak  <= 1'b0;
         irq_pipe_ack  <= 1'b0;
         irq_pipe_word <= 16'h0000;
      end else begin
         sreq_d_reg <= sreq_s;
         // a new request beats a delivery in the same cycle
         if (sreq_rise) begin
            pending_reg <= 1'b1;
            word_reg    <= word_now;
         end else if (pipe_deliver || deliver_sw) begin
            pending_reg <= 1'b0;
         end
         irq_pipe_nak  <= irq_pipe_request & ~pending_reg;
         irq_pipe_ack  <= pipe_deliver;
         irq_pipe_word <= pipe_deliver ? word_reg : 16'h0000;
      end
   end

   // media sense: absent shows no-media, return latches media-changed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         media_seen_reg <= 1'b1;
         changed_reg    <= 1'b0;
      end else begin
         media_seen_reg <= ~media_abs;
         if (media_on && !media_seen_reg)
            changed_reg <= 1'b1;
         else if (sense_ack || media_abs)
            changed_reg <= 1'b0;
      end
   end
   wire [15:0] sense_code = media_abs   ? {bridge_pin_pkg::ASC_NO_MEDIA, bridge_pin_pkg::ASQ_ZERO}
                          : changed_reg ? {bridge_pin_pkg::ASC_CHANGED, bridge_pin_pkg::ASQ_ZERO}
                          : 16'h0000;

   // read path
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire [7:0] ar_word = {s_axi_araddr[7:2], 2'b00};
   logic [31:0] rd_mux;
   logic        rd_ok;
   always_comb begin
      rd_ok  = 1'b1;
      case (ar_word)
         bridge_pin_pkg::CFG_OFS:      rd_mux = {24'h000000, cfg_reg};
         bridge_pin_pkg::GPIO_OUT_OFS: rd_mux = {26'h0000000, gpio_out_reg};
         bridge_pin_pkg::GPIO_OE_OFS:  rd_mux = {26'h0000000, gpio_oe_reg};
         bridge_pin_pkg::CTRL_OFS:     rd_mux = {29'h00000000, ctrl_reg};
         bridge_pin_pkg::STATUS_OFS:   rd_mux = {24'h000000, pending_reg, changed_reg,
                                                 media_on, eeprom_active, vbus_reg,
                                                 buspwr_s, sreq_s, 1'b0};
         bridge_pin_pkg::IRQ_WORD_OFS: rd_mux = {16'h0000, word_reg};
         bridge_pin_pkg::SENSE_OFS:    rd_mux = {16'h0000, sense_code};
         bridge_pin_pkg::DEFAULTS_OFS: rd_mux = {18'h00000, GPIO_OE_DEF, 2'b00, GPIO_OUT_DEF};
         default: begin
            rd_mux = 32'h0000_0000;
            rd_ok  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= bridge_pin_pkg::AXI_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~ar_take & ~s_axi_arready;
         if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_ok ? bridge_pin_pkg::AXI_OKAY : bridge_pin_pkg::AXI_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // pin drivers; a host-side write lands one cycle before the pins move
   wire ata_drive = vbus_reg | float_ok;
   wire spd_mode  = cfg_reg[bridge_pin_pkg::CFG_SPEED_IND_BIT];
   wire speed_bit = ~high_speed_status;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dplus_pullup_en            <= 1'b0;
         ata_pins_oe                <= 1'b0;
         ata_pullup_control_out     <= 1'b0;
         ata_pullup_control_oe      <= 1'b0;
         active_state_indicator_out <= 1'b0;
         active_state_indicator_oe  <= 1'b0;
         gpio_out                   <= 6'h00;
         gpio_oe                    <= 6'h00;
      end else begin
         dplus_pullup_en            <= vbus_reg & (boot_reg == ST_RUN);
         ata_pins_oe                <= ata_drive;
         ata_pullup_control_out     <= ata_act;
         ata_pullup_control_oe      <= ata_drive;
         active_state_indicator_out <= 1'b0;
         active_state_indicator_oe  <= ~suspend;
         gpio_out <= spd_mode ? {gpio_out_reg[5:3], speed_bit, gpio_out_reg[1:0]}
                              : gpio_out_reg;
         gpio_oe  <= spd_mode ? (gpio_oe_reg | 6'h04) : gpio_oe_reg;
      end
   end
endmodule
`default_nettype wire

//--- testbench/status_pin_monitor.sv
// port-level assertions for the bridge status pin block
`timescale 1ns/1ps
`default_nettype none
module status_pin_monitor #(
   parameter int unsigned EEPROM_CYCLES = bridge_pin_pkg::EEPROM_CYCLES
) (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        vbus_present_input,
   input wire logic        dplus_pullup_en,
   input wire logic        ata_pins_oe,
   input wire logic        ata_pullup_control_oe,
   input wire logic        active_state_indicator_out,
   input wire logic        eeprom_active,
   input wire logic        irq_pipe_request,
   input wire logic        irq_pipe_nak,
   input wire logic        irq_pipe_ack,
   input wire logic [15:0] irq_pipe_word
);
   int unsigned up_cnt;
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_n);
   // saturates so a long run never wraps back into the start-up window
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) up_cnt <= 0;
      else if (up_cnt != 32'hFFFF_FFFF) up_cnt <= up_cnt + 1;
   end
   chk_pipe_answer: assert property (irq_pipe_request |=> irq_pipe_nak ^ irq_pipe_ack)
      else $error("pipe request without a single answer");
   chk_word_idle: assert property (!irq_pipe_ack |-> irq_pipe_word == 16'h0000)
      else $error("pipe word not zero outside delivery");
   chk_word_reserved: assert property (irq_pipe_ack |->
      irq_pipe_word[15:10] == 6'h00 && irq_pipe_word[7:6] == 2'h0)
      else $error("reserved pipe word bits set");
   chk_active_state_indicator_drive: assert property (active_state_indicator_out == 1'b0)
      else $error("indicator driven high");
   chk_pullup_float: assert property (ata_pullup_control_oe == ata_pins_oe)
      else $error("pull-up enable not floating with ata pins");
   chk_eeprom_start: assert property (up_cnt == 2 |-> eeprom_active)
      else $error("eeprom window not open after reset");
   chk_eeprom_end: assert property (eeprom_active |-> up_cnt <= EEPROM_CYCLES + 4)
      else $error("eeprom window too long");
   // pin is seen through two sync stages, the poll register and the output flop
   chk_dplus_attach: assert property ($rose(dplus_pullup_en) |-> $past(vbus_present_input, 4))
      else $error("pull-up attached without vbus");
   // floating follows the polled vbus level, not the pin itself
   chk_ata_float: assert property (!ata_pins_oe |-> !dplus_pullup_en)
      else $error("ata pins floated with vbus sampled present");
endmodule
`default_nettype wire

//--- testbench/usb_host_model.sv
// usb host model that polls the interrupt pipe
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
   input wire logic        clk,
   output var logic        irq_pipe_request,
   input wire logic        irq_pipe_nak,
   input wire logic        irq_pipe_ack,
   input wire logic [15:0] irq_pipe_word
);
   initial irq_pipe_request = 1'b0;
   // gap models a host slow to schedule the token
   task automatic poll(input int gap, output logic nak, output logic ack,
                       output logic [15:0] word);
      repeat (gap) @(posedge clk);
      irq_pipe_request <= 1'b1;
      @(posedge clk);
      irq_pipe_request <= 1'b0;
      // answer stands for one cycle only: read it mid-cycle
      @(negedge clk);
      nak = irq_pipe_nak;
      ack = irq_pipe_ack;
      word = irq_pipe_word;
      @(posedge clk);
   endtask
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench for the bridge status pin logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int unsigned POLL = 50;
   localparam int unsigned EEP  = 20;
   logic        clk = 1'b0, rst_n = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        vbus_present_input = 1'b1, system_service_request = 1'b0;
   logic        removable_media_present = 1'b1, bus_powered_select = 1'b0;
   logic [5:0]  gpio_in = 6'h00, gpio_out, gpio_oe;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        dplus_pullup_en, ata_pins_oe, ata_pullup_control_out, ata_pullup_control_oe;
   logic        active_state_indicator_out, active_state_indicator_oe, eeprom_active;
   logic        irq_pipe_request, irq_pipe_nak, irq_pipe_ack;
   logic [15:0] irq_pipe_word;
   int          mismatches = 0;
   int          tests_run = 0;
   always #2.5 clk = ~clk;
   bridge_status_pins #(.POLL_CYCLES(POLL), .EEPROM_CYCLES(EEP), .GPIO_OUT_DEF(6'h15),
      .GPIO_OE_DEF(6'h2A)) DUT (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .vbus_present_input,
      .system_service_request, .removable_media_present, .bus_powered_select, .gpio_in,
      .gpio_out, .gpio_oe, .dplus_pullup_en, .ata_pins_oe, .ata_pullup_control_out,
      .ata_pullup_control_oe, .active_state_indicator_out, .active_state_indicator_oe,
      .eeprom_active, .irq_pipe_request, .irq_pipe_nak, .irq_pipe_ack, .irq_pipe_word);
   usb_host_model host (.clk, .irq_pipe_request, .irq_pipe_nak, .irq_pipe_ack,
      .irq_pipe_word);
   task automatic give_verdict();
      if (mismatches == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic idle(input int unsigned n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
                     input logic [1:0] rexp = bridge_pin_pkg::AXI_OKAY);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      check("bvalid", s_axi_bvalid, 32'h1);
      check("bresp", s_axi_bresp, rexp);
      s_axi_bready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     input logic [1:0] rexp = bridge_pin_pkg::AXI_OKAY);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      check("rvalid", s_axi_rvalid, 32'h1);
      check("rresp", s_axi_rresp, rexp);
      s_axi_rready <= 1'b0;
      @(posedge clk);
   endtask
   // detection-skip bit 6 always left clear: only a removable device is modelled
   task automatic wcfg(input logic [31:0] d);
      wr(bridge_pin_pkg::CFG_OFS, d, 4'h1);
   endtask
   task automatic wctl(input logic [31:0] d);
      wr(bridge_pin_pkg::CTRL_OFS, d, 4'h1);
   endtask
   task automatic sense_is(input logic [31:0] exp);
      logic [31:0] d;
      idle(6);
      rd(bridge_pin_pkg::SENSE_OFS, d);
      check("sense", d, exp);
   endtask
   task automatic t_start();
      logic [31:0] d;
      idle(2);
      check("eeprom_active", eeprom_active, 32'h1);
      rd(bridge_pin_pkg::DEFAULTS_OFS, d);
      check("defaults", d, 32'h2A15);
      check("gpio_out", gpio_out, 32'h15);
      check("gpio_oe", gpio_oe, 32'h2A);
      rd(bridge_pin_pkg::CFG_OFS, d);
      check("cfg", d, 32'h0);
      rd(8'h40, d, bridge_pin_pkg::AXI_SLVERR);
      check("unmapped", d, 32'h0);
      idle(EEP + 10);
      check("eeprom_active", eeprom_active, 32'h0);
      check("dplus", dplus_pullup_en, 32'h1);
   endtask
   task automatic t_vbus();
      vbus_present_input <= 1'b0;
      idle(POLL + 10);
      check("dplus", dplus_pullup_en, 32'h0);
      check("ata_oe", ata_pins_oe, 32'h0);
      check("pullup_oe", ata_pullup_control_oe, 32'h0);
      wcfg(32'h10);
      idle(POLL + 10);
      check("ata_oe", ata_pins_oe, 32'h1);
      vbus_present_input <= 1'b1;
      wcfg(32'h0);
      idle(POLL + 10);
      check("dplus", dplus_pullup_en, 32'h1);
      check("ata_oe", ata_pins_oe, 32'h1);
   endtask
   task automatic t_irq();
      logic        nk, ak;
      logic [15:0] w;
      logic [31:0] d;
      host.poll(0, nk, ak, w);
      check("nak", nk, 32'h1);
      bus_powered_select <= 1'b1;
      gpio_in <= 6'h2D;
      wctl(32'h1);
      system_service_request <= 1'b1;
      idle(6);
      rd(bridge_pin_pkg::IRQ_WORD_OFS, d);
      check("latched", d, 32'h032D);
      host.poll(3, nk, ak, w);
      check("ack", ak, 32'h1);
      check("word", w, 32'h032D);
      host.poll(0, nk, ak, w);
      check("nak", nk, 32'h1);
      system_service_request <= 1'b0;
      idle(6);
      system_service_request <= 1'b1;
      idle(6);
      wctl(32'h9);
      host.poll(0, nk, ak, w);
      check("nak", nk, 32'h1);
      system_service_request <= 1'b0;
   endtask
   task automatic t_media();
      removable_media_present <= 1'b0;
      wcfg(32'h3);
      sense_is(32'h3A00);
      removable_media_present <= 1'b1;
      sense_is(32'h2800);
      wctl(32'h10);
      sense_is(32'h0);
      wcfg(32'h1);
      sense_is(32'h3A00);
      wcfg(32'h0);
   endtask
   task automatic t_gpio();
      wr(bridge_pin_pkg::GPIO_OUT_OFS, 32'h3B, 4'h1);
      wr(bridge_pin_pkg::GPIO_OE_OFS, 32'h0F, 4'h1);
      wr(bridge_pin_pkg::GPIO_OUT_OFS, 32'h00, 4'hE);
      idle(2);
      check("gpio_out", gpio_out, 32'h3B);
      check("gpio_oe", gpio_oe, 32'h0F);
      wctl(32'h0);
      wcfg(32'h4);
      idle(2);
      check("speed_pin", gpio_out[2], 32'h1);
      check("speed_oe", gpio_oe[2], 32'h1);
      wctl(32'h1);
      idle(2);
      check("speed_pin", gpio_out[2], 32'h0);
      wcfg(32'h0);
   endtask
   task automatic t_pins();
      wctl(32'h4);
      idle(2);
      check("pullup", ata_pullup_control_out, 32'h1);
      check("ind_oe", active_state_indicator_oe, 32'h1);
      check("ind_out", active_state_indicator_out, 32'h0);
      wctl(32'h2);
      idle(2);
      check("pullup", ata_pullup_control_out, 32'h0);
      check("ind_oe", active_state_indicator_oe, 32'h0);
      wr(8'h40, 32'hFF, 4'hF, bridge_pin_pkg::AXI_SLVERR);
      check("gpio_out", gpio_out, 32'h3B);
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      mismatches++;
      give_verdict();
   end
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_start();
      t_vbus();
      t_irq();
      t_media();
      t_gpio();
      t_pins();
      give_verdict();
   end
endmodule
bind bridge_status_pins status_pin_monitor #(.EEPROM_CYCLES(EEPROM_CYCLES)) mon (.clk,
   .rst_n, .vbus_present_input, .dplus_pullup_en, .ata_pins_oe, .ata_pullup_control_oe,
   .active_state_indicator_out, .eeprom_active, .irq_pipe_request, .irq_pipe_nak,
   .irq_pipe_ack, .irq_pipe_word);
`default_nettype wire
